// *** verilog/cse_pkg.sv ***
package cse_pkg;
	// ==========================================================
	// Bus layout
	localparam int CSE_AW = 8;
	localparam logic [1:0] CSE_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSE_RESP_SLVERR = 2'h2;
	localparam logic [7:0] CSE_OFF_INSTR = 8'h00;
	localparam logic [7:0] CSE_OFF_WREG = 8'h04;
	localparam logic [7:0] CSE_OFF_STATUS = 8'h08;
	localparam logic [7:0] CSE_OFF_PC = 8'h0c;
	localparam logic [7:0] CSE_OFF_STACK = 8'h10;
	localparam logic [7:0] CSE_OFF_MEMADDR = 8'h14;
	localparam logic [7:0] CSE_OFF_MEMDATA = 8'h18;
	localparam logic [7:0] CSE_OFF_WDOG = 8'h1c;

	// ==========================================================
	// Instruction word fields
	localparam int CSE_OP_LSB = 0;
	localparam int CSE_BIT_LSB = 4;
	localparam int CSE_MADDR_LSB = 8;
	localparam int CSE_TARGET_LSB = 16;
	localparam int CSE_PC_W = 11;
	localparam int CSE_SP_W = 3;
	localparam int CSE_STACK_DEPTH = 8;
	localparam int CSE_MEM_DEPTH = 256;

	localparam logic [2:0] CSE_OP_NOP = 3'h0;
	localparam logic [2:0] CSE_OP_AND_INTO_MEMORY = 3'h1;
	localparam logic [2:0] CSE_OP_CALL = 3'h2;
	localparam logic [2:0] CSE_OP_ZEROING_BYTE = 3'h3;
	localparam logic [2:0] CSE_OP_ZEROING_BIT = 3'h4;
	localparam logic [2:0] CSE_OP_CLEAR_WATCHDOG = 3'h5;
	localparam logic [2:0] CSE_OP_INVERT = 3'h6;

	// ==========================================================
	// Status bits and reset values
	localparam int CSE_ST_ZERO = 0;
	localparam int CSE_ST_EXPIRY = 1;
	localparam int CSE_ST_POWERDOWN = 2;
	localparam int CSE_ST_BUSY = 8;
	localparam logic [CSE_PC_W-1:0] CSE_PC_RESET = 11'h000;
	localparam logic [7:0] CSE_WREG_RESET = 8'h00;
	localparam logic [7:0] CSE_BYTE_ZERO = 8'h00;
	localparam logic [15:0] CSE_WDOG_DEFAULT = 16'hffff;

	typedef enum logic [1:0] {
		CSE_IDLE,
		CSE_EXEC,
		CSE_CALL_LOAD
	} cse_state_t;
endpackage

// *** verilog/cse_top.sv ***
`timescale 1ns/1ns
// Functional notes
// - AND working register into memory byte
// - Call pushes program counter plus one
// - Call then loads target, flags untouched
// - Call takes two instruction cycles
// - Byte clear writes 00H, flags untouched
// - Bit clear zeroes one bit only
// - Watchdog clear resets counter, expiry, powerdown
// - Invert writes one's complement back
module cse_top
	import cse_pkg::*;
#(
	parameter logic [15:0] WDOG_TIMEOUT_CYCLES = CSE_WDOG_DEFAULT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CSE_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [CSE_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic powerdown_req,
	output logic busy,
	output logic expiry_flag
);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r = old_v;
		for (int i = 0; i < 4; i++) begin
			r[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic addr_mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= CSE_OFF_WDOG;
	endfunction

	// ==========================================================
	// Storage
	logic [7:0] data_mem [CSE_MEM_DEPTH];
	logic [CSE_PC_W-1:0] stack_mem [CSE_STACK_DEPTH];

	// Bus state.
	logic aw_held, next_aw_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic w_held, next_w_held;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	logic wr_fire;
	logic [31:0] rd_word;

	// Core state.
	cse_state_t state, next_state;
	logic [31:0] instr, next_instr;
	logic [7:0] working_register, next_working_register;
	logic [CSE_PC_W-1:0] pc, next_pc;
	logic [CSE_SP_W-1:0] sp, next_sp;
	logic [7:0] mem_addr, next_mem_addr;
	logic zero_flag, next_zero_flag;
	logic next_expiry_flag;
	logic powerdown_flag, next_powerdown_flag;
	logic [15:0] watchdog_counter, next_watchdog_counter;
	logic mem_we, stack_we;
	logic [7:0] mem_wa, mem_wd;
	logic [CSE_PC_W-1:0] stack_wd;
	logic [2:0] op, bit_sel;
	logic [7:0] op_addr, operand, result;
	logic [31:0] wr_val;
	logic [CSE_PC_W-1:0] pc_inc;

	assign op = instr[CSE_OP_LSB +: 3];
	assign bit_sel = instr[CSE_BIT_LSB +: 3];
	assign op_addr = instr[CSE_MADDR_LSB +: 8];
	assign operand = data_mem[op_addr];
	assign pc_inc = CSE_PC_W'(pc + 11'h001);

	// ==========================================================
	// AXI4-Lite slave
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	// A write takes effect only once both halves are in and the previous response has gone.
	assign wr_fire = aw_held && w_held && !bvalid;

	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			CSE_OFF_INSTR: rd_word = instr;
			CSE_OFF_WREG: rd_word[7:0] = working_register;
			CSE_OFF_STATUS: begin
				rd_word[CSE_ST_ZERO] = zero_flag;
				rd_word[CSE_ST_EXPIRY] = expiry_flag;
				rd_word[CSE_ST_POWERDOWN] = powerdown_flag;
				rd_word[CSE_ST_BUSY] = busy;
			end
			CSE_OFF_PC: rd_word[CSE_PC_W-1:0] = pc;
			CSE_OFF_STACK: begin
				rd_word[CSE_PC_W-1:0] = stack_mem[CSE_SP_W'(sp - 3'h1)];
				rd_word[CSE_PC_W +: CSE_SP_W] = sp;
			end
			CSE_OFF_MEMADDR: rd_word[7:0] = mem_addr;
			CSE_OFF_MEMDATA: rd_word[7:0] = data_mem[mem_addr];
			CSE_OFF_WDOG: rd_word[15:0] = watchdog_counter;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = addr_mapped(aw_addr) ? CSE_RESP_OKAY : CSE_RESP_SLVERR;
		end
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
			next_rresp = addr_mapped(s_axi_araddr) ? CSE_RESP_OKAY : CSE_RESP_SLVERR;
		end
	end

	// ==========================================================
	// Instruction execution
	always_comb begin
		next_state = state;
		next_instr = instr;
		next_working_register = working_register;
		next_pc = pc;
		next_sp = sp;
		next_mem_addr = mem_addr;
		next_zero_flag = zero_flag;
		next_expiry_flag = expiry_flag;
		next_powerdown_flag = powerdown_flag;
		next_watchdog_counter = 16'(watchdog_counter + 16'h0001);
		mem_we = 1'b0;
		mem_wa = op_addr;
		mem_wd = CSE_BYTE_ZERO;
		stack_we = 1'b0;
		stack_wd = pc_inc;
		result = CSE_BYTE_ZERO;
		wr_val = 32'h0000_0000;
		busy = state != CSE_IDLE;

		// Software writes are refused while an instruction runs, so memory and PC see one writer.
		if (wr_fire && state == CSE_IDLE) begin
			case (aw_addr)
				CSE_OFF_INSTR: begin
					next_instr = merge_strb(instr, w_data, w_strb);
					next_state = CSE_EXEC;
				end
				CSE_OFF_WREG: begin
					wr_val = merge_strb({24'h000000, working_register}, w_data, w_strb);
					next_working_register = wr_val[7:0];
				end
				CSE_OFF_PC: begin
					wr_val = merge_strb({21'h0, pc}, w_data, w_strb);
					next_pc = wr_val[CSE_PC_W-1:0];
				end
				CSE_OFF_MEMADDR: begin
					wr_val = merge_strb({24'h000000, mem_addr}, w_data, w_strb);
					next_mem_addr = wr_val[7:0];
				end
				CSE_OFF_MEMDATA: begin
					wr_val = merge_strb({24'h000000, data_mem[mem_addr]}, w_data, w_strb);
					mem_we = 1'b1;
					mem_wa = mem_addr;
					mem_wd = wr_val[7:0];
				end
				default: ;
			endcase
		end

		unique case (state)
			CSE_IDLE: ;
			CSE_EXEC: begin
				next_state = CSE_IDLE;
				next_pc = pc_inc;
				case (op)
					CSE_OP_AND_INTO_MEMORY: begin
						result = working_register & operand;
						mem_we = 1'b1;
						mem_wd = result;
						next_zero_flag = result == CSE_BYTE_ZERO;
					end
					CSE_OP_CALL: begin
						stack_we = 1'b1;
						next_sp = CSE_SP_W'(sp + 3'h1);
						next_pc = pc;
						next_state = CSE_CALL_LOAD;
					end
					CSE_OP_ZEROING_BYTE: begin
						mem_we = 1'b1;
						mem_wd = CSE_BYTE_ZERO;
					end
					CSE_OP_ZEROING_BIT: begin
						mem_we = 1'b1;
						mem_wd = operand & ~(8'h01 << bit_sel);
					end
					CSE_OP_CLEAR_WATCHDOG: begin
						next_watchdog_counter = 16'h0000;
						next_expiry_flag = 1'b0;
						next_powerdown_flag = 1'b0;
					end
					CSE_OP_INVERT: begin
						result = ~operand;
						mem_we = 1'b1;
						mem_wd = result;
						next_zero_flag = result == CSE_BYTE_ZERO;
					end
					default: ;
				endcase
			end
			CSE_CALL_LOAD: begin
				next_pc = instr[CSE_TARGET_LSB +: CSE_PC_W];
				next_state = CSE_IDLE;
			end
		endcase

		// Hardware events win over the clearing instruction in the same cycle.
		if (watchdog_counter >= 16'(WDOG_TIMEOUT_CYCLES - 16'h0001)) begin
			next_watchdog_counter = 16'h0000;
			next_expiry_flag = 1'b1;
		end
		if (powerdown_req) begin
			next_powerdown_flag = 1'b1;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= CSE_RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= CSE_RESP_OKAY;
			state <= CSE_IDLE;
			instr <= 32'h0000_0000;
			working_register <= CSE_WREG_RESET;
			pc <= CSE_PC_RESET;
			sp <= 3'h0;
			mem_addr <= 8'h00;
			zero_flag <= 1'b0;
			expiry_flag <= 1'b0;
			powerdown_flag <= 1'b0;
			watchdog_counter <= 16'h0000;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			state <= next_state;
			instr <= next_instr;
			working_register <= next_working_register;
			pc <= next_pc;
			sp <= next_sp;
			mem_addr <= next_mem_addr;
			zero_flag <= next_zero_flag;
			expiry_flag <= next_expiry_flag;
			powerdown_flag <= next_powerdown_flag;
			watchdog_counter <= next_watchdog_counter;
		end
	end

	// Data memory and stack hold no reset value; software initialises data memory, and only calls write the stack.
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			data_mem[mem_wa] <= mem_wd;
		end
		if (stack_we) begin
			stack_mem[sp] <= stack_wd;
		end
	end
endmodule

// *** bench/cse_checker.sv ***
`timescale 1ns/1ns
// ==========================================================
// Port-level protocol and timing checks
module cse_checker
	import cse_pkg::*;
#(
	parameter logic [15:0] WDOG_TIMEOUT_CYCLES = CSE_WDOG_DEFAULT
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic busy
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read not released");
	// Busy may last two cycles, as a call needs, but never a third.
	busy_max_a: assert property (busy [*2] |=> !busy)
		else $error("busy too long");
	busy_resp_a: assert property ($rose(busy) |-> s_axi_bvalid) else $error("busy without write");
	reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !busy)
		else $error("not idle after reset");

	cover property (busy [*2]);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == CSE_RESP_SLVERR);
endmodule

bind cse_top cse_checker #(.WDOG_TIMEOUT_CYCLES(WDOG_TIMEOUT_CYCLES)) cse_checker_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .busy(busy));

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench
	import cse_pkg::*;
;
	localparam logic [11:0] OPS = {CSE_OP_INVERT, CSE_OP_ZEROING_BIT, CSE_OP_ZEROING_BYTE,
		CSE_OP_AND_INTO_MEMORY};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, zf;
	logic arvalid, arready, rvalid, rready, powerdown_req, busy, expiry_flag;
	logic [7:0] awaddr, araddr, a, m, w, x;
	logic [31:0] wdata, rdata, seed;
	logic [1:0] bresp, rresp;
	logic [2:0] op, b, sp;
	logic [10:0] pc, t;
	logic [13:0] stk;
	logic [65:0] e;
	logic [1:0] bq[$];
	logic [65:0] rq[$];
	int n_fail, checks;

	// A short watchdog span keeps the timeout reachable in a brief run.
	cse_top #(.WDOG_TIMEOUT_CYCLES(16'h0010)) cse_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.powerdown_req(powerdown_req), .busy(busy), .expiry_flag(expiry_flag));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("Error %0t: port value wrong", $time);
		end
	endtask

	// ==========================================================
	// Bus master
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
		bit ta, tw;
		@(posedge aclk);
		bq.push_back(r);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			ta = ta || (awvalid && awready);
			tw = tw || (wvalid && wready);
			awvalid <= !ta;
			wvalid <= !tw;
		end while (!(ta && tw));
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] mk,
		input logic [1:0] r = CSE_RESP_OKAY);
		@(posedge aclk);
		rq.push_back({r, mk, ex});
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic exec(input logic [2:0] o, input logic [2:0] bi, input logic [7:0] ma,
		input logic [10:0] tg);
		wr(CSE_OFF_INSTR, {5'h00, tg, ma, 1'b0, bi, 1'b0, o}, CSE_RESP_OKAY);
		check(busy === 1'b1);
		@(posedge aclk);
		check(busy === (o == CSE_OP_CALL));
		@(posedge aclk);
		check(busy === 1'b0);
		pc = (o == CSE_OP_CALL) ? tg : pc + 11'h001;
	endtask

	task automatic conclude();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Result monitor
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			e = rq.pop_front();
			checks++;
			if ({rresp, rdata & e[63:32]} !== {e[65:64], e[31:0]}) begin
				n_fail++;
				$display("Error %0t: read data %h", $time, rdata);
			end
		end
		if (bvalid && bready) begin
			checks++;
			if (bresp !== bq.pop_front()) begin
				n_fail++;
				$display("Error %0t: write response %h", $time, bresp);
			end
		end
	end

	initial begin
		seed = 32'h3bed40d2;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, powerdown_req} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{zf, pc, sp} = 15'h0000;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CSE_OFF_STATUS, 32'h0, 32'h107);
		rd(CSE_OFF_PC, 32'h0, 32'hffffffff);
		rd(CSE_OFF_WREG, 32'h0, 32'hffffffff);
		wr(8'h20, 32'h0, CSE_RESP_SLVERR);
		rd(8'h20, 32'h0, 32'hffffffff, CSE_RESP_SLVERR);
		$display("test reset and map done");
		for (int i = 0; i < 24; i++) begin
			op = OPS[3*(i%4) +: 3];
			a = 8'(rnd());
			m = (i == 3) ? 8'hff : 8'(rnd());
			w = (i < 4) ? 8'h00 : 8'(rnd());
			b = 3'(rnd());
			wr(CSE_OFF_WREG, {24'h0, w}, CSE_RESP_OKAY);
			wr(CSE_OFF_MEMADDR, {24'h0, a}, CSE_RESP_OKAY);
			wr(CSE_OFF_MEMDATA, {24'h0, m}, CSE_RESP_OKAY);
			exec(op, b, a, 11'h000);
			case (op)
				CSE_OP_AND_INTO_MEMORY: x = w & m;
				CSE_OP_ZEROING_BYTE: x = CSE_BYTE_ZERO;
				CSE_OP_ZEROING_BIT: x = m & ~(8'h01 << b);
				default: x = ~m;
			endcase
			if (op == CSE_OP_AND_INTO_MEMORY || op == CSE_OP_INVERT) zf = (x == 8'h00);
			rd(CSE_OFF_MEMDATA, {24'h0, x}, 32'hff);
			rd(CSE_OFF_STATUS, {31'h0, zf}, 32'h1);
			rd(CSE_OFF_PC, {21'h0, pc}, 32'hffffffff);
		end
		$display("test data ops done");
		for (int i = 0; i < 2; i++) begin
			t = 11'(rnd());
			pc = 11'(rnd());
			wr(CSE_OFF_PC, {21'h0, pc}, CSE_RESP_OKAY);
			sp = sp + 3'h1;
			stk = {sp, pc + 11'h001};
			exec(CSE_OP_CALL, 3'h0, 8'h00, t);
			rd(CSE_OFF_PC, {21'h0, t}, 32'hffffffff);
			rd(CSE_OFF_STACK, {18'h0, stk}, 32'h3fff);
			rd(CSE_OFF_STATUS, {31'h0, zf}, 32'h1);
		end
		$display("test call done");
		powerdown_req <= 1'b1;
		repeat (20) @(posedge aclk);
		powerdown_req <= 1'b0;
		check(expiry_flag === 1'b1);
		rd(CSE_OFF_STATUS, 32'h6, 32'h6);
		// A timeout on the clearing edge keeps expiry set, so the second clear is judged.
		exec(CSE_OP_CLEAR_WATCHDOG, 3'h0, 8'h00, 11'h000);
		exec(CSE_OP_CLEAR_WATCHDOG, 3'h0, 8'h00, 11'h000);
		check(expiry_flag === 1'b0);
		rd(CSE_OFF_STATUS, {31'h0, zf}, 32'h7);
		// The counter restarts at the clearing edge and is sampled seven edges later.
		rd(CSE_OFF_WDOG, 32'h6, 32'hffff);
		$display("test watchdog done");
		repeat (4) @(posedge aclk);
		check(rq.size() == 0 && bq.size() == 0);
		conclude();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		$display("Error %0t: timeout", $time);
		n_fail++;
		conclude();
	end
endmodule
